// File: pwm_pkg.sv
/*
 * Shared constants and types for the four-channel 10-bit modulator block:
 * register map, field positions, reset values, timing and carrier structs.
 * Assumes a 100 MHz system clock that also serves as the oscillator clock.
 */
package pwm_pkg;

	// ------------------------------------------------------------
	// Sizes and timing
	// ------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int NUM_TMR = 2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TIMER_TICK_NS = 40;
	localparam int TICK_CYCLES = TIMER_TICK_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Register map: tile is address bits 7:4, sub offset bits 3:0
	// ------------------------------------------------------------
	localparam logic [3:0] TILE_TMR0 = 4'h0;
	localparam logic [3:0] TILE_COMMON = 4'h2;
	localparam logic [1:0] CH_REGION = 2'h1;
	localparam logic [3:0] SUB_TMR_CTL = 4'h0;
	localparam logic [3:0] SUB_TMR_LIMIT = 4'h4;
	localparam logic [3:0] SUB_TMR_COUNT = 4'h8;
	localparam logic [3:0] SUB_FLAGS = 4'h0;
	localparam logic [3:0] SUB_PIN_DIR = 4'h4;
	localparam logic [3:0] SUB_CH_CTL = 4'h0;
	localparam logic [3:0] SUB_CH_UPPER = 4'h4;
	localparam logic [3:0] SUB_CH_LOWER = 4'h8;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TMR_ON_BIT = 7;
	localparam int TMR_TIMER_PRESCALE_SELECT_LSB = 4;
	localparam int CTL_EN_BIT = 7;
	localparam int CTL_OUT_BIT = 5;
	localparam int CTL_POL_BIT = 4;
	localparam int CTL_TSEL_BIT = 0;
	localparam int LOWER_LSB = 6;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] LIMIT_RST = 8'hff;
	localparam logic [3:0] PIN_DIR_RST = 4'hf;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic on;
		logic [2:0] timer_prescale_select;
		logic [7:0] limit;
		logic [7:0] count;
		logic [8:0] pre;
	} timer_s;

	typedef struct packed {
		logic en;
		logic pol;
		logic tsel;
		logic [9:0] duty;
	} ch_cfg_s;

	typedef struct packed {
		logic restart;
		logic [9:0] base_next;
	} tbase_s;

	typedef struct packed {
		logic [9:0] buffer;
		logic active;
		logic out;
	} ch_state_s;

	typedef struct packed {
		timer_s [NUM_TMR-1:0] tmr;
		ch_cfg_s [NUM_CH-1:0] ch;
		logic [NUM_CH-1:0] pin_dir;
		logic [NUM_TMR-1:0] flag;
		logic ack;
		logic [31:0] dat;
	} top_state_s;

endpackage

// File: pwm_channel.sv
/*
 * One 10-bit modulator channel: shadow duty buffer, active flag and the
 * registered output level. Assumes the time base and restart pulse come
 * from the shared period timers in the parent block.
 */
`timescale 1ns/100ps
module pwm_channel
	import pwm_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic hold_i,
	input wire ch_cfg_s cfg_i,
	input wire tbase_s tb_i,
	// Output level
	output logic out_o
);

	ch_state_s st;
	ch_state_s next_st;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (!hold_i) begin
			if (tb_i.restart) begin
				next_st.buffer = cfg_i.duty; // RQ4
				next_st.active = (cfg_i.duty != 10'h000); // RQ3
			end else if (tb_i.base_next == st.buffer) begin
				// Duty above the period never matches, so the pin stays put
				next_st.active = 1'b0; // RQ19 RQ7 RQ8
			end
			next_st.out = cfg_i.en ? (next_st.active ^ cfg_i.pol) : cfg_i.pol; // RQ10 RQ11
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0; // RQ15
		end else begin
			st <= next_st;
		end
	end

	assign out_o = st.out;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_SHADOW_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
		tb_i.restart && !hold_i |=> st.buffer == $past(cfg_i.duty))
		else $error("Duty buffer did not load at restart");
	AST_SHADOW_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
		!tb_i.restart |=> $stable(st.buffer))
		else $error("Duty buffer changed mid-period");
	AST_ZERO_DUTY: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
		tb_i.restart && !hold_i && cfg_i.duty == 10'h000 |=> out_o == $past(cfg_i.pol))
		else $error("Zero duty drove the active level");
	AST_SET_AT_START: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
		tb_i.restart && !hold_i && cfg_i.en && cfg_i.duty != 10'h000 |=> out_o != $past(cfg_i.pol))
		else $error("Output not active at period start");
	AST_MATCH_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
		!tb_i.restart && !hold_i && tb_i.base_next == st.buffer |=> out_o == $past(cfg_i.pol))
		else $error("Output not inactive after duty match");
	AST_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
		!hold_i && !cfg_i.en |=> out_o == $past(cfg_i.pol))
		else $error("Disabled channel left idle level");
	AST_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
		hold_i |=> $stable(out_o) && $stable(st.buffer) && $stable(st.active))
		else $error("Channel state moved during sleep");

endmodule

// File: pwm_quad.sv
/*
 * Four independent 10-bit modulators sharing two 8-bit period timers,
 * with a classic Wishbone register slave. Assumes the system clock is the
 * oscillator clock and that the bus master follows single classic cycles.
 */
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
// Summary of operation
// (RQ1) Period equals limit plus one, times four clocks, times prescale.
// (RQ2) Increment after count matches limit clears count and starts a period.
// (RQ3) Output goes active at period start unless buffered duty is zero.
// (RQ4) Duty written anytime; shadow buffer loads only at period restart.
// (RQ5) Duty is ten bits: upper register eight MSBs, lower bits 7:6 LSBs.
// (RQ6) Time base is count plus two low bits from clock phase or prescaler.
// (RQ7) Active width equals duty times clock period times prescale.
// (RQ8) Active fraction equals duty over four times limit plus one.
// (RQ9) Resolution is log2 of four times limit plus one, ten bits at 255.
// (RQ10) Polarity picks idle level; active drive is the opposite level.
// (RQ11) With enable cleared the output holds the idle level.
// (RQ12) Software selects the prescale of the quarter-rate clock for the period timer.
// (RQ13) Each channel selects its own timer independently.
// (RQ14) In sleep timers stop, state freezes, outputs hold, resume on wake.
// (RQ15) Reset returns all registers to reset values and pins to input.
// (RQ16) Software setup order: driver off, polarity, period, duty, timer, enable.
// (RQ17) Software may enable together with polarity if a full first cycle is optional.
// (RQ18) Four identical independent channels, each with own control and duty.
// (RQ19) When time base equals buffered duty the output goes inactive.
// (RQ20) Extension bits clear with the count at each period restart.
`timescale 1ns/100ps
module pwm_quad
	import pwm_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Power state
	input wire logic sleep_i,
	// Pins
	output logic [NUM_CH-1:0] pwm_o,
	output logic [NUM_CH-1:0] pwm_oe_n_o
);

	top_state_s st;
	top_state_s next_st;
	tbase_s [NUM_TMR-1:0] tb;
	logic [NUM_TMR-1:0] restart;
	logic [NUM_TMR-1:0] set_flag;
	logic [NUM_CH-1:0] level;
	logic [31:0] rdata;
	logic bus_req;
	logic wr;
	logic [3:0] tile;
	logic [3:0] sub;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Last value of the oscillator-cycle counter before a timer step
	function automatic logic [8:0] pre_last(input logic [2:0] timer_prescale_select);
		logic [8:0] span;
		span = 9'(TICK_CYCLES) << timer_prescale_select; // RQ1 RQ12
		return span - 9'h001;
	endfunction

	// Quarter-step bits: clock phase at 1:1, prescaler bits otherwise
	function automatic logic [1:0] ext_bits(input logic [8:0] pre, input logic [2:0] timer_prescale_select);
		logic [8:0] shifted;
		shifted = pre >> timer_prescale_select; // RQ6
		return shifted[1:0];
	endfunction

	// ------------------------------------------------------------
	// Timers and register file
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		restart = '0;
		set_flag = '0;
		rdata = UNMAPPED_READ;
		bus_req = cyc_i && stb_i && !st.ack;
		wr = bus_req && we_i && sel_i[0];
		tile = adr_i[7:4];
		sub = adr_i[3:0];

		// Timers freeze in sleep; the held count resumes on wake
		for (int t = 0; t < NUM_TMR; t++) begin
			if (st.tmr[t].on && !sleep_i) begin // RQ14
				if (st.tmr[t].pre == pre_last(st.tmr[t].timer_prescale_select)) begin
					next_st.tmr[t].pre = 9'h000; // RQ20
					if (st.tmr[t].count == st.tmr[t].limit) begin
						next_st.tmr[t].count = 8'h00; // RQ2
						restart[t] = 1'b1; // RQ2
						set_flag[t] = 1'b1;
					end else begin
						next_st.tmr[t].count = st.tmr[t].count + 8'h01;
					end
				end else begin
					next_st.tmr[t].pre = st.tmr[t].pre + 9'h001;
				end
			end
		end

		// Timer tiles
		for (int t = 0; t < NUM_TMR; t++) begin
			if (tile == TILE_TMR0 + 4'(t)) begin
				case (sub)
					SUB_TMR_CTL: begin
						rdata[TMR_ON_BIT] = st.tmr[t].on;
						rdata[TMR_TIMER_PRESCALE_SELECT_LSB +: 3] = st.tmr[t].timer_prescale_select;
						if (wr) begin
							next_st.tmr[t].on = dat_i[TMR_ON_BIT];
							next_st.tmr[t].timer_prescale_select = dat_i[TMR_TIMER_PRESCALE_SELECT_LSB +: 3];
						end
					end
					SUB_TMR_LIMIT: begin
						rdata[7:0] = st.tmr[t].limit;
						if (wr) begin
							next_st.tmr[t].limit = dat_i[7:0]; // RQ9
						end
					end
					SUB_TMR_COUNT: begin
						rdata[7:0] = st.tmr[t].count;
						// A count write also restarts the quarter steps
						if (wr) begin
							next_st.tmr[t].count = dat_i[7:0];
							next_st.tmr[t].pre = 9'h000;
						end
					end
					default: begin
						rdata = UNMAPPED_READ;
					end
				endcase
			end
		end

		// Common tile: restart flags and pin directions
		if (tile == TILE_COMMON) begin
			case (sub)
				SUB_FLAGS: begin
					rdata[NUM_TMR-1:0] = st.flag;
					if (wr) begin
						next_st.flag = st.flag & ~dat_i[NUM_TMR-1:0];
					end
				end
				SUB_PIN_DIR: begin
					rdata[NUM_CH-1:0] = st.pin_dir;
					if (wr) begin
						next_st.pin_dir = dat_i[NUM_CH-1:0];
					end
				end
				default: begin
					rdata = UNMAPPED_READ;
				end
			endcase
		end

		// Channel tiles
		for (int c = 0; c < NUM_CH; c++) begin
			if (adr_i[7:6] == CH_REGION && adr_i[5:4] == 2'(c)) begin
				case (sub)
					SUB_CH_CTL: begin
						rdata[CTL_EN_BIT] = st.ch[c].en;
						rdata[CTL_OUT_BIT] = level[c];
						rdata[CTL_POL_BIT] = st.ch[c].pol;
						rdata[CTL_TSEL_BIT] = st.ch[c].tsel;
						if (wr) begin
							next_st.ch[c].en = dat_i[CTL_EN_BIT];
							next_st.ch[c].pol = dat_i[CTL_POL_BIT];
							next_st.ch[c].tsel = dat_i[CTL_TSEL_BIT]; // RQ13
						end
					end
					SUB_CH_UPPER: begin
						rdata[7:0] = st.ch[c].duty[9:2];
						if (wr) begin
							next_st.ch[c].duty[9:2] = dat_i[7:0]; // RQ5
						end
					end
					SUB_CH_LOWER: begin
						rdata[LOWER_LSB +: 2] = st.ch[c].duty[1:0];
						if (wr) begin
							next_st.ch[c].duty[1:0] = dat_i[LOWER_LSB +: 2]; // RQ5
						end
					end
					default: begin
						rdata = UNMAPPED_READ;
					end
				endcase
			end
		end

		// A restart in the clearing cycle keeps its flag
		next_st.flag = next_st.flag | set_flag;
		next_st.ack = bus_req;
		next_st.dat = bus_req ? rdata : 32'h0000_0000;

		for (int t = 0; t < NUM_TMR; t++) begin
			tb[t].restart = restart[t];
			tb[t].base_next = {next_st.tmr[t].count, ext_bits(next_st.tmr[t].pre, next_st.tmr[t].timer_prescale_select)}; // RQ6 RQ9
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0; // RQ15
			st.pin_dir <= PIN_DIR_RST; // RQ15
			for (int t = 0; t < NUM_TMR; t++) begin
				st.tmr[t].limit <= LIMIT_RST;
			end
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		pwm_channel u_ch ( // RQ18
			.clk_i(clk_i),
			.rst_i(rst_i),
			.hold_i(sleep_i),
			.cfg_i(st.ch[c]),
			.tb_i(tb[st.ch[c].tsel]), // RQ13
			.out_o(level[c])
		);
	end

	assign pwm_o = level;
	assign pwm_oe_n_o = st.pin_dir;
	assign dat_o = st.dat;
	assign ack_o = st.ack;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Oscillator cycles since the last restart of timer 0
	logic [16:0] per_cnt;
	logic per_valid;
	logic tmr0_wr;
	logic [16:0] per_expect;

	assign tmr0_wr = wr && tile == TILE_TMR0;
	assign per_expect = 17'(({9'h000, st.tmr[0].limit} + 17'h00001) << (4'(st.tmr[0].timer_prescale_select) + 4'h2)) - 17'h00001;

	always_ff @(posedge clk_i) begin
		if (rst_i || tmr0_wr) begin
			per_cnt <= 17'h00000;
			per_valid <= 1'b0;
		end else if (restart[0]) begin
			per_cnt <= 17'h00000;
			per_valid <= 1'b1;
		end else if (st.tmr[0].on && !sleep_i) begin
			per_cnt <= per_cnt + 17'h00001;
		end
	end

	AST_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
		restart[0] && per_valid |-> per_cnt == per_expect)
		else $error("Timer period length wrong");
	AST_COUNT_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
		restart[0] && !tmr0_wr |=> st.tmr[0].count == 8'h00 && st.tmr[0].pre == 9'h000)
		else $error("Count not cleared at restart");
	AST_EXT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
		restart[1] |=> ext_bits(st.tmr[1].pre, st.tmr[1].timer_prescale_select) == 2'h0)
		else $error("Extension bits not cleared at restart");
	AST_SLEEP_TIMER: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
		sleep_i && !wr |=> $stable(st.tmr) && $stable(pwm_o))
		else $error("Timer moved during sleep");
	AST_RESET_PIN: assert property (@(posedge clk_i) // RQ15
		rst_i |=> pwm_oe_n_o == PIN_DIR_RST && pwm_o == '0 && !ack_o && st.ch == '0)
		else $error("Reset did not release pins");
	AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		restart[0] |=> st.flag[0])
		else $error("Restart flag lost");
	AST_NO_RESTART_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
		!st.tmr[1].on |-> !restart[1] ##1 (st.tmr[1].count == $past(st.tmr[1].count) || $past(wr)))
		else $error("Stopped timer advanced");

	// Same period check for the second timer, which runs the prescaled channel
	logic [16:0] per1_cnt;
	logic per1_valid;
	logic tmr1_wr;
	logic [16:0] per1_expect;

	assign tmr1_wr = wr && tile == TILE_TMR0 + 4'h1;
	assign per1_expect = 17'(({9'h000, st.tmr[1].limit} + 17'h00001) << (4'(st.tmr[1].timer_prescale_select) + 4'h2)) - 17'h00001;

	always_ff @(posedge clk_i) begin
		if (rst_i || tmr1_wr) begin
			per1_cnt <= 17'h00000;
			per1_valid <= 1'b0;
		end else if (restart[1]) begin
			per1_cnt <= 17'h00000;
			per1_valid <= 1'b1;
		end else if (st.tmr[1].on && !sleep_i) begin
			per1_cnt <= per1_cnt + 17'h00001;
		end
	end

	AST_PERIOD_T1: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
		restart[1] && per1_valid |-> per1_cnt == per1_expect)
		else $error("Second timer period length wrong");

	// ------------------------------------------------------------
	// Bus and register checks
	// ------------------------------------------------------------
	// Registered answer: one wait state, then a one-cycle pulse
	AST_ACK_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("Request not answered in the next cycle");
	AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("Acknowledge held longer than one cycle");
	AST_DAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
		!ack_o |-> dat_o == 32'h0000_0000)
		else $error("Read data not zero outside acknowledge");
	AST_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && tile == TILE_COMMON && sub == SUB_FLAGS && dat_i[0] && !restart[0] |=> !st.flag[0])
		else $error("Restart flag not cleared by write");
	// Set wins over a clear in the same cycle
	AST_FLAG_SET_T1: assert property (@(posedge clk_i) disable iff (rst_i)
		restart[1] |=> st.flag[1])
		else $error("Second restart flag lost");
	AST_PIN_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && tile == TILE_COMMON && sub == SUB_PIN_DIR |=> pwm_oe_n_o == $past(dat_i[NUM_CH-1:0]))
		else $error("Pin direction write not applied");
	AST_COUNT_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && tile == TILE_TMR0 && sub == SUB_TMR_COUNT |=> st.tmr[0].count == $past(dat_i[7:0]) && st.tmr[0].pre == 9'h000)
		else $error("Count write not applied");
	AST_DUTY_UPPER: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
		wr && adr_i[7:6] == CH_REGION && adr_i[5:4] == 2'h0 && sub == SUB_CH_UPPER |=> st.ch[0].duty[9:2] == $past(dat_i[7:0]))
		else $error("Upper duty bits not stored");
	AST_DUTY_LOWER: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
		wr && adr_i[7:6] == CH_REGION && adr_i[5:4] == 2'h0 && sub == SUB_CH_LOWER |=> st.ch[0].duty[1:0] == $past(dat_i[LOWER_LSB +: 2]))
		else $error("Lower duty bits not stored");
	AST_CTL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
		wr && adr_i[7:6] == CH_REGION && adr_i[5:4] == 2'h1 && sub == SUB_CH_CTL |=> st.ch[1].tsel == $past(dat_i[CTL_TSEL_BIT]) && st.ch[1].pol == $past(dat_i[CTL_POL_BIT]))
		else $error("Channel control write not applied");

endmodule

// File: pwm_load_model.sv
/*
 * Switched load on one modulator pin: measures the last high run and the
 * rise-to-rise period of the level that the load sees.
 * Assumes one sample per system clock and a weak pull-down on the pin.
 */
`timescale 1ns/100ps
module pwm_load_model (
	// Clock
	input wire logic clk_i,
	// Pin
	input wire logic pin_i,
	input wire logic oe_n_i,
	// Measurements
	output logic [11:0] hi_w_o,
	output logic [11:0] per_o
);
	logic lvl;
	logic prev = 1'b0;
	logic [11:0] run = 12'h000;
	logic [11:0] cyc = 12'h000;

	initial hi_w_o = 12'h000;
	initial per_o = 12'h000;

	// Undriven pin falls to the pull-down, never to the last level
	assign lvl = oe_n_i ? 1'b0 : pin_i;

	always @(posedge clk_i) begin
		prev <= lvl;
		run <= lvl ? run + 12'h001 : 12'h000;
		if (!lvl && prev) begin
			hi_w_o <= run;
		end
		if (lvl && !prev) begin
			per_o <= cyc;
			cyc <= 12'h001;
		end else begin
			cyc <= cyc + 12'h001;
		end
	end
endmodule

// File: pwm_quad_test.sv
/*
 * Self-checking bench for the four-channel modulator: Wishbone register
 * tasks, a load model on every pin and directed tests.
 * Assumes the register map and timing constants of the block's package.
 */
`timescale 1ns/100ps
module pwm_quad_test;
	import pwm_pkg::*;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o;
	logic ack_o;
	logic sleep_i = 1'b0;
	logic [NUM_CH-1:0] pwm_o;
	logic [NUM_CH-1:0] pwm_oe_n_o;
	logic [11:0] hi_w [NUM_CH];
	logic [11:0] per [NUM_CH];
	int n_errors = 0;
	int total_checks = 0;
	logic [31:0] rd;
	logic [31:0] held;
	logic b;

	always #5 clk_i = ~clk_i;

	pwm_quad u_pwm_quad (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i),
		.pwm_o(pwm_o), .pwm_oe_n_o(pwm_oe_n_o));

	for (genvar g = 0; g < NUM_CH; g++) begin : loads
		pwm_load_model u_pwm_load_model (.clk_i(clk_i), .pin_i(pwm_o[g]), .oe_n_i(pwm_oe_n_o[g]),
			.hi_w_o(hi_w[g]), .per_o(per[g]));
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h000000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk(what, {24'h000000, exp}, rd);
	endtask

	task automatic wait_pin(input int c, input logic v);
		do @(posedge clk_i); while (pwm_o[c] !== v);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("pin enables", 32'hf, {28'h0, pwm_oe_n_o});
		chk("pin levels", 32'h0, {28'h0, pwm_o});
		rdchk("limit0", 8'h04, 8'hff);
		rdchk("pin dir", 8'h24, 8'h0f);
		rdchk("duty upper", 8'h44, 8'h00);
		wb(1'b1, 8'h3c, 8'h5a);
		rdchk("unmapped", 8'h3c, 8'h00);
		$display("test reset done");

		wb(1'b1, 8'h24, 8'h0f);
		wb(1'b1, 8'h40, 8'h00);
		wb(1'b1, 8'h04, 8'h03);
		wb(1'b1, 8'h44, 8'h03);
		wb(1'b1, 8'h48, 8'h40);
		wb(1'b1, 8'h20, 8'h03);
		wb(1'b1, 8'h00, 8'h80);
		do wb(1'b0, 8'h20, 8'h00); while (rd[0] !== 1'b1);
		wb(1'b1, 8'h24, 8'h00);
		wb(1'b1, 8'h40, 8'h80);
		// Second channel on its own timer, enabled with polarity at once
		wb(1'b1, 8'h14, 8'h03);
		wb(1'b1, 8'h54, 8'h01);
		wb(1'b1, 8'h58, 8'h40);
		wb(1'b1, 8'h50, 8'h91);
		wb(1'b1, 8'h10, 8'ha0);
		wb(1'b1, 8'h60, 8'h10);
		wb(1'b1, 8'h70, 8'h80);
		repeat (200) @(posedge clk_i);
		chk("ch0 period", 16, per[0]);
		chk("ch0 width", 13, hi_w[0]);
		chk("ch1 period", 64, per[1]);
		chk("ch1 high part", 44, hi_w[1]);
		chk("ch2 idle", 1, pwm_o[2]);
		rdchk("ch2 ctl", 8'h60, 8'h30);
		b = 1'b0;
		repeat (40) begin
			@(posedge clk_i);
			b = b | pwm_o[3];
		end
		chk("ch3 zero duty", 0, b);
		$display("test setup and channels done");

		// Duty 2 written early in a pulse: old width must finish first
		wait_pin(0, 1'b0);
		wait_pin(0, 1'b1);
		wb(1'b1, 8'h44, 8'h00);
		wb(1'b1, 8'h48, 8'h80);
		wait_pin(0, 1'b0);
		repeat (2) @(posedge clk_i);
		chk("width before reload", 13, hi_w[0]);
		wait_pin(0, 1'b1);
		wait_pin(0, 1'b0);
		repeat (2) @(posedge clk_i);
		chk("width after reload", 2, hi_w[0]);
		$display("test double buffer done");

		sleep_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		b = pwm_o[0];
		wb(1'b0, 8'h08, 8'h00);
		held = rd;
		repeat (30) @(posedge clk_i);
		chk("sleep pin", {31'h0, b}, {31'h0, pwm_o[0]});
		rdchk("sleep count", 8'h08, held[7:0]);
		sleep_i <= 1'b0;
		$display("test sleep done");

		wb(1'b1, 8'h04, 8'hff);
		wb(1'b1, 8'h44, 8'hff);
		wb(1'b1, 8'h48, 8'hc0);
		repeat (2200) @(posedge clk_i);
		chk("full period", 1024, per[0]);
		chk("full width", 1023, hi_w[0]);
		$display("test resolution done");
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		complete_run();
	end
endmodule
